//--- shared/tsic_defs.svh
`ifndef TSIC_DEFS_SVH
`define TSIC_DEFS_SVH

// Register bus offsets
`define TSIC_ADDR_CTRL 4'h0
`define TSIC_ADDR_STAT 4'h1
`define TSIC_ADDR_VEC 4'h2

// Control register bit positions
`define TSIC_BIT_GLOBAL 0
`define TSIC_BIT_PIN_EN 1
`define TSIC_BIT_TMR_EN 2
`define TSIC_BIT_CONV_EN 3
`define TSIC_BIT_PIN_FLAG 4
`define TSIC_BIT_TMR_FLAG 5
`define TSIC_BIT_CONV_FLAG 6

// Reset value of the control register
`define TSIC_CTRL_RST 7'h00

// Vector addresses
`define TSIC_VEC_PIN 8'h04
`define TSIC_VEC_TMR 8'h08
`define TSIC_VEC_CONV 8'h0c

// Vector shown before any call has been made
`define TSIC_VEC_NONE 8'h00

`endif

//--- shared/tsic_pkg.sv
package tsic_pkg;
   typedef enum logic [1:0] {
      TSIC_SRC_NONE,
      TSIC_SRC_PIN,
      TSIC_SRC_TMR,
      TSIC_SRC_CONV
   } tsic_src_t;
endpackage : tsic_pkg

//--- src/tsic_ctrl.sv
`timescale 1ns/1ns
`include "tsic_defs.svh"
module tsic_ctrl
   import tsic_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic second_phase_pulse,
   input wire logic shared_port_pin,
   input wire logic shared_pin_direction_bit,
   input wire logic pull_high_option,
   input wire logic timer_overflow,
   input wire logic conv_done,
   input wire logic stack_full,
   input wire logic power_down,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq_call,
   output logic [7:0] irq_vector,
   output logic wake_up,
   output logic pin_pull_high
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge detect

   logic pin_sync1;
   logic pin_sync2;
   logic pin_prev;
   logic pin_fall;

   // Two stages since the pin is asynchronous
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_sync1 <= 1'b1;
         pin_sync2 <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         pin_sync1 <= shared_port_pin;
         pin_sync2 <= pin_sync1;
         pin_prev <= pin_sync2;
      end
   end

   logic global_irq_enable;
   logic pin_irq_enable;
   logic timer_irq_enable;
   logic conv_irq_enable;
   logic pin_irq_flag;
   logic timer_irq_flag;
   logic conv_irq_flag;

   // Reset word indexed by field; shifting the whole word would
   // drop six bits silently onto each one-bit flop
   // Each field takes its own bit of it
   localparam logic [6:0] CTRL_RST = `TSIC_CTRL_RST;

   // Falling edge only in interrupt mode
   assign pin_fall = pin_prev & ~pin_sync2 & pin_irq_enable
                     & shared_pin_direction_bit;

   assign pin_pull_high = pull_high_option;

   ////////////////////////////////////////////////////////////////////////
   // Arbitration

   logic pin_ready;
   logic tmr_ready;
   logic conv_ready;
   logic grant;
   tsic_src_t winner;

   // Global and own enable gate each source
   assign pin_ready = global_irq_enable & pin_irq_enable & pin_irq_flag;
   assign tmr_ready = global_irq_enable & timer_irq_enable
                      & timer_irq_flag;
   assign conv_ready = global_irq_enable & conv_irq_enable
                       & conv_irq_flag;

   always_comb begin
      if (pin_ready) begin
         winner = TSIC_SRC_PIN;
      end else if (tmr_ready) begin
         winner = TSIC_SRC_TMR;
      end else if (conv_ready) begin
         winner = TSIC_SRC_CONV;
      end else begin
         winner = TSIC_SRC_NONE;
      end
   end

   // Grant on phase-two pulse, never with stack full
   // A request landing between two pulses waits for the later one;
   // a full stack only defers it, the flag stays set
   // and the arbitration result is sampled only on that pulse
   assign grant = second_phase_pulse & ~stack_full
                  & (winner != TSIC_SRC_NONE);

   ////////////////////////////////////////////////////////////////////////
   // Control register

   logic wr_ctrl;
   logic serve_pin;
   logic serve_tmr;
   logic serve_conv;
   logic [7:0] wd;

   assign wr_ctrl = reg_wr & (reg_addr == `TSIC_ADDR_CTRL);
   assign wd = reg_wdata;
   assign serve_pin = grant & (winner == TSIC_SRC_PIN);
   assign serve_tmr = grant & (winner == TSIC_SRC_TMR);
   assign serve_conv = grant & (winner == TSIC_SRC_CONV);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_irq_enable <= CTRL_RST[`TSIC_BIT_PIN_EN];
      end else if (wr_ctrl) begin
         pin_irq_enable <= wd[`TSIC_BIT_PIN_EN];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timer_irq_enable <= CTRL_RST[`TSIC_BIT_TMR_EN];
      end else if (wr_ctrl) begin
         timer_irq_enable <= wd[`TSIC_BIT_TMR_EN];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         conv_irq_enable <= CTRL_RST[`TSIC_BIT_CONV_EN];
      end else if (wr_ctrl) begin
         conv_irq_enable <= wd[`TSIC_BIT_CONV_EN];
      end
   end

   // Service clears global enable, overriding a write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         global_irq_enable <= CTRL_RST[`TSIC_BIT_GLOBAL];
      end else if (grant) begin
         global_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         global_irq_enable <= wd[`TSIC_BIT_GLOBAL];
      end
   end

   // Pin edge sets the pin flag
   // Set wins over service and write, so no edge is lost
   tsic_flag #(
      .RST_VAL(CTRL_RST[`TSIC_BIT_PIN_FLAG])
   ) u_pin_flag (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .set_evt(pin_fall),
      .serve(serve_pin),
      .wr_en(wr_ctrl),
      .wr_bit(wd[`TSIC_BIT_PIN_FLAG]),
      .flag(pin_irq_flag)
   );

   // Overflow sets the timer flag
   // Overflow is seen even while the timer source is masked
   tsic_flag #(
      .RST_VAL(CTRL_RST[`TSIC_BIT_TMR_FLAG])
   ) u_tmr_flag (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .set_evt(timer_overflow),
      .serve(serve_tmr),
      .wr_en(wr_ctrl),
      .wr_bit(wd[`TSIC_BIT_TMR_FLAG]),
      .flag(timer_irq_flag)
   );

   // Conversion end sets the conversion flag
   // Lowest priority, so it may wait behind the other two
   tsic_flag #(
      .RST_VAL(CTRL_RST[`TSIC_BIT_CONV_FLAG])
   ) u_conv_flag (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .set_evt(conv_done),
      .serve(serve_conv),
      .wr_en(wr_ctrl),
      .wr_bit(wd[`TSIC_BIT_CONV_FLAG]),
      .flag(conv_irq_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // Call request to the sequencer

   logic [7:0] next_vector;

   always_comb begin
      case (winner)
         TSIC_SRC_PIN: next_vector = `TSIC_VEC_PIN;
         TSIC_SRC_TMR: next_vector = `TSIC_VEC_TMR;
         TSIC_SRC_CONV: next_vector = `TSIC_VEC_CONV;
         default: next_vector = `TSIC_VEC_NONE;
      endcase
   end

   // One-cycle call pulse; the core pushes only its counter
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_call <= 1'b0;
      end else begin
         irq_call <= grant;
      end
   end

   // Vector loads with the call and holds for later reads
   // Holding it lets software see which source was served last
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_vector <= `TSIC_VEC_NONE;
      end else if (grant) begin
         irq_vector <= next_vector;
      end
   end

   logic any_enabled_pending;

   // Any enabled pending flag may wake the core
   // Global enable is ignored: a sleeping core must wake first to
   // re-enable it, or it would sleep through its own interrupts
   assign any_enabled_pending = (pin_irq_enable & pin_irq_flag)
                                | (timer_irq_enable & timer_irq_flag)
                                | (conv_irq_enable & conv_irq_flag);

   // Registered wake request, only while asleep
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wake_up <= 1'b0;
      end else begin
         wake_up <= power_down & any_enabled_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe

   logic [7:0] ctrl_word;
   logic [7:0] stat_word;
   logic [7:0] next_rdata;

   assign ctrl_word = {1'b0, conv_irq_flag, timer_irq_flag, pin_irq_flag,
                       conv_irq_enable, timer_irq_enable, pin_irq_enable,
                       global_irq_enable};
   // Stack state beside the current winner
   assign stat_word = {5'h00, stack_full, winner};

   // Unmapped offsets read as zero
   always_comb begin
      case (reg_addr)
         `TSIC_ADDR_CTRL: next_rdata = ctrl_word;
         `TSIC_ADDR_STAT: next_rdata = stat_word;
         `TSIC_ADDR_VEC: next_rdata = irq_vector;
         default: next_rdata = 8'h00;
      endcase
   end

   // Data stands for one cycle only and reads zero otherwise, so a
   // stale value can never pass for a fresh answer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : tsic_ctrl

////////////////////////////////////////////////////////////////////////
// One request flag: set by hardware, cleared by service or software.
// Kept as its own module since three sources share the same rules.

module tsic_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic set_evt,
   input wire logic serve,
   input wire logic wr_en,
   input wire logic wr_bit,
   output logic flag
);

   // Holds until served or rewritten by software
   // An event in the clearing cycle wins, so it is never lost
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flag <= RST_VAL;
      end else if (set_evt) begin
         flag <= 1'b1;
      end else if (serve) begin
         flag <= 1'b0;
      end else if (wr_en) begin
         flag <= wr_bit;
      end
   end

endmodule : tsic_flag

//--- verification/test_three_source_interrupt_ctrl.sv
`timescale 1ns/1ns
`include "tsic_defs.svh"
module test_three_source_interrupt_ctrl;
   logic core_clk = 0, sys_rst = 1, pin = 1, tmr = 0, conv = 0;
   logic dir = 1, pullo = 1;
   logic pdn = 0, full = 0, wr = 0, rd = 0, call, wake, pull, pulse, sfull;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, rdata, vec, c, m, v, f;
   int fail_count = 0, checks = 0, cyc = 0;
   logic seen;
   // Rows: enables, events {conv,tmr,pin}, vector, control after
   logic [31:0] rows [7] = '{
      32'h03010402, 32'h05020804,
      32'h09040c08, 32'h0f07046e,
      32'h0d07084c, 32'h0e07007e,
      32'h01020021};
   always #5 core_clk = ~core_clk;
   tsic_ctrl u_tsic_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
      .second_phase_pulse(pulse), .shared_port_pin(pin),
      .shared_pin_direction_bit(dir), .pull_high_option(pullo),
      .timer_overflow(tmr), .conv_done(conv), .stack_full(sfull),
      .power_down(pdn), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .irq_call(call), .irq_vector(vec),
      .wake_up(wake), .pin_pull_high(pull));
   tsic_core_model u_tsic_core_model (.core_clk(core_clk),
      .sys_rst(sys_rst), .hold_full(full), .second_phase_pulse(pulse),
      .stack_full(sfull));
   ////////////////////////////////////////////////////////////////////////
   task chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(logic [3:0] a, logic [7:0] e);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(posedge core_clk);
      chk("reg_rdata", e, rdata);
   endtask : rd_reg
   // Pin falls first so its synchroniser delay cannot reorder sources
   task fire(logic [2:0] ev);
      @(posedge core_clk);
      pin <= !ev[0];
      repeat (4) @(posedge core_clk);
      pin <= 1'b1;
      tmr <= ev[1];
      conv <= ev[2];
      @(posedge core_clk);
      tmr <= 1'b0;
      conv <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : fire
   // Three phase-two periods is ample for a grant
   task wait_call;
      seen = 1'b0;
      repeat (12) begin
         @(posedge core_clk);
         if (call === 1'b1) seen = 1'b1;
      end
   endtask : wait_call
   task test_done;
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // Hang guard, well above the few hundred cycles expected
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_reg(`TSIC_ADDR_CTRL, {1'b0, `TSIC_CTRL_RST});
      rd_reg(`TSIC_ADDR_STAT, 8'h00);
      rd_reg(4'h3, 8'h00);
      foreach (rows[i]) begin
         c = rows[i][31:24];
         m = rows[i][23:16];
         v = rows[i][15:8];
         f = {1'b0, m[2:1], m[0] & c[1], 4'h0};
         wr_reg(`TSIC_ADDR_CTRL, c & 8'hfe);
         fire(m[2:0]);
         rd_reg(`TSIC_ADDR_CTRL, (c & 8'hfe) | f);
         // Global enable back to the row's value, flags kept as read
         wr_reg(`TSIC_ADDR_CTRL, c | f);
         wait_call();
         chk("irq_call", {7'h0, v != 0}, {7'h0, seen});
         if (v != 0) chk("irq_vector", v, vec);
         rd_reg(`TSIC_ADDR_CTRL, rows[i][7:0]);
      end
      // Full stack holds the grant until it drains
      full <= 1'b1;
      wr_reg(`TSIC_ADDR_CTRL, 8'h04);
      fire(3'h2);
      wr_reg(`TSIC_ADDR_CTRL, 8'h25);
      wait_call();
      chk("held", 8'h00, {7'h0, seen});
      full <= 1'b0;
      wait_call();
      chk("released", 8'h01, {7'h0, seen});
      // Sleeping core woken by an enabled pending flag
      pdn <= 1'b1;
      wr_reg(`TSIC_ADDR_CTRL, 8'h04);
      fire(3'h2);
      chk("wake_up", 8'h01, {7'h0, wake});
      // Pin set as output: its edges are ignored
      pdn <= 1'b0;
      dir <= 1'b0;
      wr_reg(`TSIC_ADDR_CTRL, 8'h02);
      fire(3'h1);
      rd_reg(`TSIC_ADDR_CTRL, 8'h02);
      dir <= 1'b1;
      pullo <= 1'b0;
      @(posedge core_clk);
      chk("pin_pull_high", 8'h00, {7'h0, pull});
      // Reset in mid-run brings the control word back
      wr_reg(`TSIC_ADDR_CTRL, 8'h7e);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_reg(`TSIC_ADDR_CTRL, {1'b0, `TSIC_CTRL_RST});
      test_done();
   end
endmodule : test_three_source_interrupt_ctrl

//--- verification/tsic_chk.sv
`timescale 1ns/1ns
`include "tsic_defs.svh"
// Port-level checks of grant, vector and register read timing
module tsic_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic second_phase_pulse,
   input wire logic pull_high_option,
   input wire logic stack_full,
   input wire logic power_down,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic irq_call,
   input wire logic [7:0] irq_vector,
   input wire logic wake_up,
   input wire logic pin_pull_high
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Read strobe at one offset
   sequence rd_of(logic [3:0] a);
      reg_rd && reg_addr == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Grant only on a phase-two pulse with room on the stack
   call_on_pulse_a: assert property (irq_call |->
      $past(second_phase_pulse))
      else $error("call without phase-two pulse");
   full_blocks_a: assert property ($past(stack_full) |-> !irq_call)
      else $error("call while stack full");
   vec_legal_a: assert property (irq_call |-> irq_vector inside
      {`TSIC_VEC_PIN, `TSIC_VEC_TMR, `TSIC_VEC_CONV})
      else $error("illegal vector");
   // Global enable cleared by the grant, so no call follows at once
   no_back_call_a: assert property (irq_call |=> !irq_call [*3])
      else $error("second call without re-enable");
   vec_holds_a: assert property (!irq_call |-> $stable(irq_vector))
      else $error("vector moved without call");
   pull_kept_a: assert property (pin_pull_high == pull_high_option)
      else $error("pull-high option lost");
   wake_asleep_a: assert property (wake_up |-> $past(power_down))
      else $error("wake while awake");
   rdata_idle_a: assert property (!$past(reg_rd) |->
      reg_rdata == 8'h00)
      else $error("read data outside read answer");
   stat_full_a: assert property (rd_of(`TSIC_ADDR_STAT) |=>
      reg_rdata[2] == $past(stack_full))
      else $error("status stack bit wrong");
endmodule : tsic_chk

bind tsic_ctrl tsic_chk u_tsic_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .second_phase_pulse(second_phase_pulse), .stack_full(stack_full),
   .pull_high_option(pull_high_option), .power_down(power_down),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq_call(irq_call), .irq_vector(irq_vector), .wake_up(wake_up),
   .pin_pull_high(pin_pull_high));

//--- verification/tsic_core_model.sv
`timescale 1ns/1ns
// Core side: machine-cycle phase pulse and stack state
module tsic_core_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hold_full,
   output logic second_phase_pulse,
   output logic stack_full
);
   logic [1:0] phase;
   // One phase-two pulse every four cycles, never two in a row
   always_ff @(posedge core_clk) begin
      phase <= sys_rst ? 2'h0 : phase + 2'h1;
      second_phase_pulse <= !sys_rst && phase == 2'h3;
   end
   // Stack depth is bench-controlled; no sequencer is modelled
   // Routines here make no nested calls, so one level suffices
   assign stack_full = hold_full;
endmodule : tsic_core_model
